// [rtl/pgh_pkg.sv]
// Notes on behaviour
// - Port G data latch is always readable and writable, untouched by reset.
// - Port G direction bit one makes an output, zero an input; resets zero.
// - Port H pins 0-3 carry PWM; 4/5 and 6/7 carry serial two/three rx/tx.
// - Every port H pin comes out of reset as an input, pulled up on 7-4 and down on 3-0.
// - Port H data latch is free to use; owned pins ignore written values.
// - Port H direction bit one makes an output, zero an input; resets zero.
// - B, F, G have pull-ups; H has up on 7-4, down on 3-0, one enable.
// - Pull register holds H,G,F,B enables in bits 3-0, resets 0F, top zero.
// - Global pull enable clear turns every pull resistor off.
// - In expanded mode the F and B pull enables do nothing.
// - Port C open-drain option bit makes port C drivers open-drain.
// - LIR option bit set drives a high pulse; clear only drives low.
// - Stretch option bit adds one E cycle to every off-chip access.
// - Expanded mode: visibility bit puts internal reads on the data bus.
// - Single chip: visibility bit set holds E low, clear drives E clock.
// - LSB-first option bit selects serial port bit order.
// - ROM placement set puts ROM high; clear puts it low in expanded mode.
// - Security disable bit one turns EEPROM security off.
// - Watchdog disable bit one turns the watchdog off.
// - Setup bits 1 and 0 map ROM and EEPROM; bits 6 and 5 read one.
// - Port G pin 7 is the read/write strobe in expanded and test modes.
package pgh_pkg;
  // ---------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [6:0] IDX_PULL_ASSIGNMENT    = 7'h2C;
  localparam logic [6:0] IDX_SYSTEM_OPTIONS_TWO = 7'h38;
  localparam logic [6:0] IDX_SYSTEM_SETUP       = 7'h3F;
  localparam logic [6:0] IDX_PORT_H_DATA        = 7'h7C;
  localparam logic [6:0] IDX_PORT_H_DIRECTION   = 7'h7D;
  localparam logic [6:0] IDX_PORT_G_DATA        = 7'h7E;
  localparam logic [6:0] IDX_PORT_G_DIRECTION   = 7'h7F;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int PULL_B = 0;
  localparam int PULL_F = 1;
  localparam int PULL_G = 2;
  localparam int PULL_H = 3;
  localparam int OPT_SPI_RATE = 2;
  localparam int OPT_LSB      = 3;
  localparam int OPT_VIS      = 4;
  localparam int OPT_STRETCH  = 5;
  localparam int OPT_OPEN_DR  = 6;
  localparam int OPT_LIR      = 7;
  localparam int SET_EEPROM   = 0;
  localparam int SET_ROM      = 1;
  localparam int SET_WDOG     = 2;
  localparam int SET_SEC      = 3;
  localparam int SET_GLOBAL_PULL_REGISTER_ENABLE    = 4;
  localparam int SET_ROMPL    = 7;
  // ---------------------------------------------------------------
  // Reset values and fixed read bits
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_PULL      = 4'hF;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [5:0] RST_OPTIONS   = 6'h00;
  localparam logic [7:0] SETUP_ONES    = 8'h60;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage

// [rtl/pgh_top.sv]
`timescale 1ns/1ps
module pgh_top
  import pgh_pkg::*;
#(
  parameter int         ADDR_W    = 12,
  parameter logic [7:0] RST_SETUP = 8'hFF
)(
  input  wire logic              I_CLK,
  input  wire logic              I_RST_B,
  input  wire logic [ADDR_W-1:0] I_AWADDR,
  input  wire logic              I_AWVALID,
  output logic                   O_AWREADY,
  input  wire logic [31:0]       I_WDATA,
  input  wire logic [3:0]        I_WSTRB,
  input  wire logic              I_WVALID,
  output logic                   O_WREADY,
  output logic [1:0]             O_BRESP,
  output logic                   O_BVALID,
  input  wire logic              I_BREADY,
  input  wire logic [ADDR_W-1:0] I_ARADDR,
  input  wire logic              I_ARVALID,
  output logic                   O_ARREADY,
  output logic [31:0]            O_RDATA,
  output logic [1:0]             O_RRESP,
  output logic                   O_RVALID,
  input  wire logic              I_RREADY,
  input  wire logic              I_EXPANDED,
  input  wire logic              I_RW_STROBE,
  input  wire logic [3:0]        I_PWM_OUT,
  input  wire logic [3:0]        I_PWM_EN,
  input  wire logic              I_SER2_EN,
  input  wire logic              I_SER2_TX,
  input  wire logic              I_SER3_EN,
  input  wire logic              I_SER3_TX,
  input  wire logic [7:0]        I_PB_DIR,
  input  wire logic [7:0]        I_PF_DIR,
  input  wire logic [7:0]        I_PG_IN,
  output logic [7:0]             O_PG_OUT,
  output logic [7:0]             O_PG_OE_B,
  output logic [7:0]             O_PG_PULL_UP,
  input  wire logic [7:0]        I_PH_IN,
  output logic [7:0]             O_PH_OUT,
  output logic [7:0]             O_PH_OE_B,
  output logic [7:0]             O_PH_PULL_UP,
  output logic [7:0]             O_PH_PULL_DOWN,
  output logic [7:0]             O_PB_PULL_UP,
  output logic [7:0]             O_PF_PULL_UP,
  output logic                   O_SER2_RX,
  output logic                   O_SER3_RX,
  output logic                   O_PC_OPEN_DRAIN,
  output logic                   O_LIR_DRIVE_HIGH,
  output logic                   O_STRETCH,
  output logic                   O_READ_VISIBLE,
  output logic                   O_E_PIN_LOW,
  output logic                   O_SPI_LSB_FIRST,
  output logic                   O_SPI_RATE_EXTRA,
  output logic                   O_ROM_UPPER,
  output logic                   O_SECURITY_OFF,
  output logic                   O_WATCHDOG_OFF,
  output logic                   O_ROM_PRESENT,
  output logic                   O_EEPROM_PRESENT
);

  // Address must reach the highest register index
  if (ADDR_W < 10 || ADDR_W > 32)
    $error("ADDR_W must lie between 10 and 32");

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0]        port_g_data;
  logic [7:0]        port_g_direction;
  logic [7:0]        port_h_data;
  logic [7:0]        port_h_direction;
  logic [3:0]        pull_assignment;
  logic [5:0]        system_options_two;
  logic [7:0]        system_setup;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0]        w_byte;
  logic              w_lane0;
  logic              aw_held;
  logic              w_held;

  // ---------------------------------------------------------------
  // Write channel handshake
  // ---------------------------------------------------------------
  wire aw_take  = I_AWVALID & O_AWREADY;
  wire w_take   = I_WVALID & O_WREADY;
  wire do_write = aw_held & w_held & ~O_BVALID;
  wire next_aw_held = (aw_held | aw_take) & ~do_write;
  wire next_w_held  = (w_held | w_take) & ~do_write;
  wire next_bvalid  = do_write | (O_BVALID & ~I_BREADY);

  // Write decode on the held address
  wire [6:0] w_idx     = aw_addr[8:2];
  wire       w_hi_zero = (aw_addr[ADDR_W-1:9] == '0);
  wire       w_ok      = w_hi_zero & (aw_addr[1:0] == 2'h0);
  wire       wr        = do_write & w_lane0;
  wire wr_pull  = wr & w_ok & (w_idx == IDX_PULL_ASSIGNMENT);
  wire wr_opt   = wr & w_ok & (w_idx == IDX_SYSTEM_OPTIONS_TWO);
  wire wr_setup = wr & w_ok & (w_idx == IDX_SYSTEM_SETUP);
  wire wr_hdat  = wr & w_ok & (w_idx == IDX_PORT_H_DATA);
  wire wr_hdir  = wr & w_ok & (w_idx == IDX_PORT_H_DIRECTION);
  wire wr_gdat  = wr & w_ok & (w_idx == IDX_PORT_G_DATA);
  wire wr_gdir  = wr & w_ok & (w_idx == IDX_PORT_G_DIRECTION);
  wire w_mapped = wr_pull | wr_opt | wr_setup | wr_hdat | wr_hdir
                | wr_gdat | wr_gdir;
  wire [1:0] next_bresp = (w_mapped | ~w_lane0) ? RESP_OKAY : RESP_SLVERR;

  // Handshake state and response
  always_ff @(posedge I_CLK or negedge I_RST_B)
    if (!I_RST_B)
    begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= RESP_OKAY;
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
    end
    else
    begin
      aw_held   <= next_aw_held;
      w_held    <= next_w_held;
      O_BVALID  <= next_bvalid;
      O_AWREADY <= ~next_aw_held & ~next_bvalid;
      O_WREADY  <= ~next_w_held & ~next_bvalid;
      if (do_write)
        O_BRESP <= next_bresp;
    end

  // Captured address and data, no reset needed
  always_ff @(posedge I_CLK)
  begin
    if (aw_take)
      aw_addr <= I_AWADDR;
    if (w_take)
    begin
      w_byte  <= I_WDATA[7:0];
      w_lane0 <= I_WSTRB[0];
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RST_B)
    if (!I_RST_B)
    begin
      port_g_direction   <= RST_DIRECTION;
      port_h_direction   <= RST_DIRECTION;
      pull_assignment    <= RST_PULL;
      system_options_two <= RST_OPTIONS;
      system_setup       <= RST_SETUP | SETUP_ONES;
    end
    else
    begin
      if (wr_gdir)
        port_g_direction <= w_byte;
      if (wr_hdir)
        port_h_direction <= w_byte;
      if (wr_pull)
        pull_assignment <= w_byte[3:0];
      if (wr_opt)
        system_options_two <= w_byte[7:2];
      if (wr_setup)
        system_setup <= w_byte | SETUP_ONES;
    end

  // Data latches, kept through reset
  always_ff @(posedge I_CLK)
  begin
    if (wr_gdat)
      port_g_data <= w_byte;
    if (wr_hdat)
      port_h_data <= w_byte;
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  wire       ar_take   = I_ARVALID & O_ARREADY;
  wire [6:0] r_idx     = I_ARADDR[8:2];
  wire       r_ok      = (I_ARADDR[ADDR_W-1:9] == '0)
                       & (I_ARADDR[1:0] == 2'h0);
  wire [7:0] opt_word  = {system_options_two, 2'h0};
  wire       r_mapped  = r_ok & ((r_idx == IDX_PULL_ASSIGNMENT)
                       | (r_idx == IDX_SYSTEM_OPTIONS_TWO)
                       | (r_idx == IDX_SYSTEM_SETUP)
                       | (r_idx[6:2] == IDX_PORT_H_DATA[6:2]));
  // Read word selection, upper bits zero
  wire [7:0] rd_byte =
      !r_ok                          ? 8'h00 :
      (r_idx == IDX_PULL_ASSIGNMENT)    ? {4'h0, pull_assignment} :
      (r_idx == IDX_SYSTEM_OPTIONS_TWO) ? opt_word :
      (r_idx == IDX_SYSTEM_SETUP)       ? system_setup :
      (r_idx == IDX_PORT_H_DATA)        ? port_h_data :
      (r_idx == IDX_PORT_H_DIRECTION)   ? port_h_direction :
      (r_idx == IDX_PORT_G_DATA)        ? port_g_data :
      (r_idx == IDX_PORT_G_DIRECTION)   ? port_g_direction : 8'h00;
  wire next_rvalid = ar_take | (O_RVALID & ~I_RREADY);

  // Read response registers
  always_ff @(posedge I_CLK or negedge I_RST_B)
    if (!I_RST_B)
    begin
      O_RVALID  <= 1'b0;
      O_ARREADY <= 1'b0;
      O_RDATA   <= 32'h0000_0000;
      O_RRESP   <= RESP_OKAY;
    end
    else
    begin
      O_RVALID  <= next_rvalid;
      O_ARREADY <= ~next_rvalid;
      if (ar_take)
      begin
        O_RDATA <= {24'h00_0000, rd_byte};
        O_RRESP <= r_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end

  // ---------------------------------------------------------------
  // Pin ownership and pulls
  // ---------------------------------------------------------------
  wire       global_pull_register_enable  = system_setup[SET_GLOBAL_PULL_REGISTER_ENABLE];
  wire [7:0] h_alt  = {I_SER3_EN, I_SER3_EN, I_SER2_EN, I_SER2_EN,
                       I_PWM_EN};
  wire [7:0] h_altv = {I_SER3_TX, 1'b0, I_SER2_TX, 1'b0,
                       I_PWM_OUT};
  wire [7:0] h_alto = {1'b1, 1'b0, 1'b1, 1'b0, 4'hF};   // Alt drives pin
  wire [7:0] g_alt  = {I_EXPANDED, 7'h00};
  wire [7:0] g_altv = {I_RW_STROBE, 7'h00};
  wire pull_h = global_pull_register_enable & pull_assignment[PULL_H];
  wire pull_g = global_pull_register_enable & pull_assignment[PULL_G];
  wire pull_f = global_pull_register_enable & pull_assignment[PULL_F] & ~I_EXPANDED;
  wire pull_b = global_pull_register_enable & pull_assignment[PULL_B] & ~I_EXPANDED;

  logic [7:0] next_g_out;
  logic [7:0] next_g_drv;
  logic [7:0] next_h_out;
  logic [7:0] next_h_drv;
  logic [7:0] next_g_pull;
  logic [7:0] next_h_pull;
  logic [7:0] next_b_pull;
  logic [7:0] next_f_pull;

  // Per-pin drive and pull selection
  for (genvar i = 0; i < 8; i++)
  begin : g_pin
    assign next_g_drv[i]  = g_alt[i] | port_g_direction[i];
    assign next_g_out[i]  = g_alt[i] ? g_altv[i] : port_g_data[i];
    assign next_h_drv[i]  = h_alt[i] ? h_alto[i]
                                     : port_h_direction[i];
    assign next_h_out[i]  = h_alt[i] ? h_altv[i] : port_h_data[i];
    assign next_g_pull[i] = pull_g & ~next_g_drv[i];
    assign next_h_pull[i] = pull_h & ~next_h_drv[i];
    assign next_b_pull[i] = pull_b & ~I_PB_DIR[i];
    assign next_f_pull[i] = pull_f & ~I_PF_DIR[i];
  end

  // Pin outputs, floating inputs during reset
  always_ff @(posedge I_CLK or negedge I_RST_B)
    if (!I_RST_B)
    begin
      O_PG_OUT       <= 8'h00;
      O_PG_OE_B      <= 8'hFF;
      O_PH_OUT       <= 8'h00;
      O_PH_OE_B      <= 8'hFF;
      O_PG_PULL_UP   <= 8'h00;
      O_PH_PULL_UP   <= 8'h00;
      O_PH_PULL_DOWN <= 8'h00;
      O_PB_PULL_UP   <= 8'h00;
      O_PF_PULL_UP   <= 8'h00;
      O_SER2_RX      <= 1'b1;
      O_SER3_RX      <= 1'b1;
    end
    else
    begin
      O_PG_OUT       <= next_g_out;
      O_PG_OE_B      <= ~next_g_drv;
      O_PH_OUT       <= next_h_out;
      O_PH_OE_B      <= ~next_h_drv;
      O_PG_PULL_UP   <= next_g_pull;
      O_PH_PULL_UP   <= {next_h_pull[7:4], 4'h0};
      O_PH_PULL_DOWN <= {4'h0, next_h_pull[3:0]};
      O_PB_PULL_UP   <= next_b_pull;
      O_PF_PULL_UP   <= next_f_pull;
      O_SER2_RX      <= I_PH_IN[4];
      O_SER3_RX      <= I_PH_IN[6];
    end

  // ---------------------------------------------------------------
  // System option and setup outputs
  // ---------------------------------------------------------------
  wire vis = system_options_two[OPT_VIS-2];
  always_ff @(posedge I_CLK or negedge I_RST_B)
    if (!I_RST_B)
    begin
      O_PC_OPEN_DRAIN  <= 1'b0;
      O_LIR_DRIVE_HIGH <= 1'b0;
      O_STRETCH        <= 1'b0;
      O_READ_VISIBLE   <= 1'b0;
      O_E_PIN_LOW      <= 1'b0;
      O_SPI_LSB_FIRST  <= 1'b0;
      O_SPI_RATE_EXTRA <= 1'b0;
      O_ROM_UPPER      <= 1'b1;
      O_SECURITY_OFF   <= 1'b0;
      O_WATCHDOG_OFF   <= 1'b0;
      O_ROM_PRESENT    <= 1'b0;
      O_EEPROM_PRESENT <= 1'b0;
    end
    else
    begin
      O_PC_OPEN_DRAIN  <= system_options_two[OPT_OPEN_DR-2];
      O_LIR_DRIVE_HIGH <= system_options_two[OPT_LIR-2];
      O_STRETCH        <= system_options_two[OPT_STRETCH-2];
      O_READ_VISIBLE   <= vis & I_EXPANDED;
      O_E_PIN_LOW      <= vis & ~I_EXPANDED;
      O_SPI_LSB_FIRST  <= system_options_two[OPT_LSB-2];
      O_SPI_RATE_EXTRA <= system_options_two[OPT_SPI_RATE-2];
      O_ROM_UPPER      <= system_setup[SET_ROMPL] | ~I_EXPANDED;
      O_SECURITY_OFF   <= system_setup[SET_SEC];
      O_WATCHDOG_OFF   <= system_setup[SET_WDOG];
      O_ROM_PRESENT    <= system_setup[SET_ROM];
      O_EEPROM_PRESENT <= system_setup[SET_EEPROM];
    end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  // Direction write reaches the pin enable two edges later
  g_dir_a: assert property (wr_gdir & ~I_EXPANDED ##1 ~I_EXPANDED
    |=> O_PG_OE_B == ~port_g_direction)
    else $error("port G enable not following direction");
  // Owned H pin shows the alternate value, not the latch
  h_alt_a: assert property (h_alt[0]
    |=> O_PH_OUT[0] == $past(I_PWM_OUT[0]))
    else $error("port H owned pin not carrying PWM");
  h_dir_a: assert property (~|h_alt ##1 ~|h_alt
    |-> O_PH_OE_B == ~$past(port_h_direction))
    else $error("port H enable not following direction");
  h_pull_a: assert property (O_PH_PULL_UP[3:0] == 4'h0
    && O_PH_PULL_DOWN[7:4] == 4'h0)
    else $error("port H pull polarity wrong");
  pull_rd_a: assert property (ar_take && r_ok
    && r_idx == IDX_PULL_ASSIGNMENT |=> O_RDATA[7:4] == 4'h0
    && O_RDATA[3:0] == $past(pull_assignment))
    else $error("pull register read wrong");
  pull_off_a: assert property (!global_pull_register_enable |=> O_PG_PULL_UP == 8'h00
    && O_PH_PULL_UP == 8'h00 && O_PH_PULL_DOWN == 8'h00)
    else $error("pulls on while globally disabled");
  bf_expand_a: assert property (I_EXPANDED |=> O_PB_PULL_UP == 8'h00
    && O_PF_PULL_UP == 8'h00)
    else $error("B or F pull active in expanded mode");
  e_pin_a: assert property (##1 O_E_PIN_LOW
    |-> $past(vis) && !$past(I_EXPANDED) && !O_READ_VISIBLE)
    else $error("E pin low outside single chip mode");
  rom_map_a: assert property (!I_EXPANDED |=> O_ROM_UPPER)
    else $error("ROM placed low in single chip mode");
  setup_ones_a: assert property (system_setup[6:5] == 2'h3)
    else $error("setup bits 6 and 5 not one");
  pull_pin_a: assert property ((O_PG_PULL_UP & ~O_PG_OE_B) == 8'h00)
    else $error("pull active on a driven pin");

endmodule // pgh_top

// [verification/pgh_pins_model.sv]
`timescale 1ns/1ps
module pgh_pins_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic [7:0] i_oe_b,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_pull_up,
  input  wire logic [7:0] i_pull_down,
  input  wire logic [7:0] i_ext_en,
  input  wire logic [7:0] i_ext_val,
  output logic [7:0]      o_level
);
  logic [7:0] float_pat;
  // Undriven, unpulled pins show a pattern that flips every cycle
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b) float_pat <= 8'h55;
    else float_pat <= ~float_pat;
  // Wire level: device driver, outside driver, then resistors
  always_comb
    for (int k = 0; k < 8; k++)
      o_level[k] = !i_oe_b[k] ? i_out[k] : i_ext_en[k] ? i_ext_val[k] :
                   i_pull_up[k] ? 1'b1 :
                   i_pull_down[k] ? 1'b0 : float_pat[k];
endmodule // pgh_pins_model

// [verification/pgh_top_tb.sv]
`timescale 1ns/1ps
module pgh_top_tb;
  import pgh_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, expanded, rw;
  logic        s2_en, s2_tx, s3_en, s3_tx, s2_rx, s3_rx, pc_od, lir;
  logic        stretch, rvis, e_low, lsb, rate, rom_up, sec, wd, rom, ee;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, pwm_out, pwm_en;
  logic [1:0]  bresp, rresp, resp;
  logic [7:0]  pb_dir, pf_dir, pg_in, pg_out, pg_oe_b, pg_pu, ph_in;
  logic [7:0]  ph_out, ph_oe_b, ph_pu, ph_pd, pb_pu, pf_pu, ext_en, rd_val;
  int          n_fail, n_compared;
  // ----------------------------------------------------------------
  // Design, pin models
  // ----------------------------------------------------------------
  pgh_top pgh_top_i (.I_CLK(clk), .I_RST_B(rst_b), .I_AWADDR(awaddr),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
    .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
    .I_RREADY(rready), .I_EXPANDED(expanded), .I_RW_STROBE(rw),
    .I_PWM_OUT(pwm_out), .I_PWM_EN(pwm_en), .I_SER2_EN(s2_en),
    .I_SER2_TX(s2_tx), .I_SER3_EN(s3_en), .I_SER3_TX(s3_tx),
    .I_PB_DIR(pb_dir), .I_PF_DIR(pf_dir), .I_PG_IN(pg_in),
    .O_PG_OUT(pg_out), .O_PG_OE_B(pg_oe_b), .O_PG_PULL_UP(pg_pu),
    .I_PH_IN(ph_in), .O_PH_OUT(ph_out), .O_PH_OE_B(ph_oe_b),
    .O_PH_PULL_UP(ph_pu), .O_PH_PULL_DOWN(ph_pd), .O_PB_PULL_UP(pb_pu),
    .O_PF_PULL_UP(pf_pu), .O_SER2_RX(s2_rx), .O_SER3_RX(s3_rx),
    .O_PC_OPEN_DRAIN(pc_od), .O_LIR_DRIVE_HIGH(lir), .O_STRETCH(stretch),
    .O_READ_VISIBLE(rvis), .O_E_PIN_LOW(e_low), .O_SPI_LSB_FIRST(lsb),
    .O_SPI_RATE_EXTRA(rate), .O_ROM_UPPER(rom_up), .O_SECURITY_OFF(sec),
    .O_WATCHDOG_OFF(wd), .O_ROM_PRESENT(rom), .O_EEPROM_PRESENT(ee));
  pgh_pins_model pgh_pins_model_i (.i_clk(clk), .i_rst_b(rst_b),
    .i_oe_b(ph_oe_b), .i_out(ph_out), .i_pull_up(ph_pu),
    .i_pull_down(ph_pd), .i_ext_en(ext_en), .i_ext_val(8'h00),
    .o_level(ph_in));
  pgh_pins_model pgh_pins_model_g (.i_clk(clk), .i_rst_b(rst_b),
    .i_oe_b(pg_oe_b), .i_out(pg_out), .i_pull_up(pg_pu),
    .i_pull_down(8'h00), .i_ext_en(8'h00), .i_ext_val(8'h00),
    .o_level(pg_in));
  // ----------------------------------------------------------------
  // Bus tasks and helpers
  // ----------------------------------------------------------------
  function automatic logic [11:0] ad(input logic [6:0] i);
    return {3'h0, i, 2'h0};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  // Write: both channels offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 50);
    resp   = bresp;
    bready <= 1'b0;
    if (t >= 50) n_fail++;
  endtask
  task automatic rd(input logic [11:0] a);
    int t;
    t = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 50);
    resp   = rresp;
    rd_val = rdata[7:0];
    rready <= 1'b0;
    if (t >= 50) n_fail++;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(pg_oe_b & ph_oe_b, 8'hFF);
    rd(ad(IDX_PORT_G_DIRECTION));
    chk(rd_val, 8'h00);
    rd(ad(IDX_PORT_H_DIRECTION));
    chk(rd_val, 8'h00);
    rd(ad(IDX_PULL_ASSIGNMENT));
    chk(rd_val, 8'h0F);
    rd(12'h004);
    chk(8'(resp), 8'h02);
    wr(12'h004, 8'hFF);
    chk(8'(resp), 8'h02);
    // Write with lane zero off is ignored but still answered OKAY
    wstrb <= 4'h0;
    wr(ad(IDX_PORT_H_DIRECTION), 8'hFF);
    chk(8'(resp), 8'h00);
    wstrb <= 4'hF;
    rd(ad(IDX_PORT_H_DIRECTION));
    chk(rd_val, 8'h00);
  endtask
  task automatic t_pull();
    chk(ph_pu, 8'hF0);
    chk(ph_pd, 8'h0F);
    chk(pg_pu & pb_pu & pf_pu, 8'hFF);
    wr(ad(IDX_PULL_ASSIGNMENT), 8'hF4);
    rd(ad(IDX_PULL_ASSIGNMENT));
    chk(rd_val, 8'h04);
    settle();
    chk(ph_pu | ph_pd | pb_pu | pf_pu | ~pg_pu, 8'h00);
    wr(ad(IDX_PULL_ASSIGNMENT), 8'h0F);
    wr(ad(IDX_SYSTEM_SETUP), 8'h6F);
    settle();
    chk(ph_pu | ph_pd | pg_pu | pb_pu | pf_pu, 8'h00);
    wr(ad(IDX_SYSTEM_SETUP), 8'hFF);
    expanded <= 1'b1;
    settle();
    chk(pb_pu | pf_pu, 8'h00);
    chk(pg_pu, 8'h7F);
    expanded <= 1'b0;
    pb_dir   <= 8'h0F;
    settle();
    chk(pb_pu, 8'hF0);
    pb_dir   <= 8'h00;
  endtask
  task automatic t_port_g();
    wr(ad(IDX_PORT_G_DATA), 8'hA5);
    wr(ad(IDX_PORT_G_DIRECTION), 8'hF0);
    settle();
    chk(pg_oe_b, 8'h0F);
    chk(pg_out & 8'hF0, 8'hA0);
    chk(pg_pu, 8'h0F);
    rd(ad(IDX_PORT_G_DATA));
    chk(rd_val, 8'hA5);
    expanded <= 1'b1;
    settle();
    chk(8'({pg_oe_b[7], pg_out[7]}), 8'h00);
    rw       <= 1'b1;
    wr(ad(IDX_PORT_G_DATA), 8'h25);
    settle();
    chk(8'({pg_oe_b[7], pg_out[7]}), 8'h01);
    expanded <= 1'b0;
    wr(ad(IDX_PORT_G_DIRECTION), 8'h00);
  endtask
  task automatic t_port_h();
    wr(ad(IDX_PORT_H_DATA), 8'h00);
    wr(ad(IDX_PORT_H_DIRECTION), 8'hFF);
    settle();
    chk(ph_oe_b | ph_out | ph_pu | ph_pd, 8'h00);
    pwm_en  <= 4'hF;
    pwm_out <= 4'h5;
    s2_en   <= 1'b1;
    s3_en   <= 1'b1;
    s3_tx   <= 1'b1;
    ext_en  <= 8'h40;
    wr(ad(IDX_PORT_H_DATA), 8'hFF);
    settle();
    chk(ph_out & 8'hAF, 8'h85);
    chk(ph_oe_b, 8'h50);
    chk(8'({s2_rx, s3_rx}), 8'h02);
    pwm_en  <= 4'h0;
    s2_en   <= 1'b0;
    s3_en   <= 1'b0;
    ext_en  <= 8'h00;
    settle();
    chk(ph_out, 8'hFF);
    wr(ad(IDX_PORT_H_DIRECTION), 8'h00);
  endtask
  task automatic t_options();
    for (int b = 2; b < 8; b++)
    begin
      wr(ad(IDX_SYSTEM_OPTIONS_TWO), 8'(1 << b));
      settle();
      chk({lir, pc_od, stretch, e_low, lsb, rate, rvis, 1'b0},
          8'(1 << b));
    end
    expanded <= 1'b1;
    wr(ad(IDX_SYSTEM_OPTIONS_TWO), 8'hFF);
    settle();
    chk(8'({rvis, e_low}), 8'h02);
    rd(ad(IDX_SYSTEM_OPTIONS_TWO));
    chk(rd_val, 8'hFC);
    expanded <= 1'b0;
  endtask
  task automatic t_setup();
    wr(ad(IDX_SYSTEM_SETUP), 8'h8F);
    settle();
    chk({rom_up, sec, wd, rom, ee, 3'h0}, 8'hF8);
    rd(ad(IDX_SYSTEM_SETUP));
    chk(rd_val, 8'hEF);
    wr(ad(IDX_SYSTEM_SETUP), 8'h10);
    settle();
    chk({rom_up, sec, wd, rom, ee, 3'h0}, 8'h80);
    expanded <= 1'b1;
    settle();
    chk(8'(rom_up), 8'h00);
  endtask
  // Mid-run reset keeps both data latches, clears direction
  task automatic t_keep();
    wr(ad(IDX_PORT_H_DATA), 8'h3C);
    wr(ad(IDX_PORT_G_DIRECTION), 8'hFF);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    chk(pg_oe_b, 8'hFF);
    rd(ad(IDX_PORT_H_DATA));
    chk(rd_val, 8'h3C);
    rd(ad(IDX_PORT_G_DATA));
    chk(rd_val, 8'h25);
    rd(ad(IDX_PORT_G_DIRECTION));
    chk(rd_val, 8'h00);
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, expanded, rw} = '0;
    {s2_en, s2_tx, s3_en, s3_tx, pwm_out, pwm_en} = '0;
    {awaddr, araddr, wdata, pb_dir, pf_dir, ext_en} = '0;
    wstrb = 4'hF;
    n_fail = 0;
    n_compared = 0;
    rst_b = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    t_reset();
    t_pull();
    t_port_g();
    t_port_h();
    t_keep();
    t_options();
    t_setup();
    wrap_up();
  end
endmodule // pgh_top_tb
